// ===== sep_fifo.sv
// file: parameterised fifo with a registered output stage
`timescale 1ns/1ps
module sep_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // filling side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // draining side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    // depth must be a power of two so the pointers wrap on their own
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH]; // storage entries
    logic [AW-1:0] wr_ptr_q; // next entry to fill
    logic [AW-1:0] rd_ptr_q; // next entry to drain
    logic [AW:0] count_q; // entries held, output stage excluded
    logic push; // entry written this cycle
    logic pop; // entry moved to output stage

    assign o_in_ready = (count_q != FULL_CNT);
    assign push = i_in_valid && o_in_ready;
    assign pop = (count_q != '0) && (!o_out_valid || i_out_ready);

    // storage write, no reset needed on data
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + AW'(1);
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // output stage keeps the drain side straight from flops
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_out_valid <= 1'b0;
            o_out_data <= '0;
        end
        else if (pop)
        begin
            o_out_valid <= 1'b1;
            o_out_data <= mem_q[rd_ptr_q];
        end
        else if (i_out_ready)
        begin
            o_out_valid <= 1'b0;
        end
    end
endmodule

// ===== sep_host.sv
// host serial bus model: mode 0 sessions, pause, read back
`timescale 1ns/1ps
module sep_host
(
    // serial pins
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    output logic o_hold_n,
    input wire logic i_so
);
    logic [7:0] rx_q; // last byte read
    initial
    begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
        o_hold_n = 1'b1;
    end
    // select falls well before the first clock edge
    task automatic open_s();
        #43 o_cs_n = 1'b0;
        #40;
    endtask
    task automatic close_s();
        #80 o_cs_n = 1'b1;
        #80;
    endtask
    // clock stands low outside frames; pause only with clock low
    task automatic xbyte(input logic [7:0] tx, input logic pause);
        for (int i = 7; i >= 0; i--)
        begin
            o_si = tx[i];
            if (pause && i == 3)
            begin
                // wait past the falling edge so its shift still sees pause high
                #20 o_hold_n = 1'b0;
                #60 o_sck = 1'b1;
                #80 o_sck = 1'b0;
                #80 o_hold_n = 1'b1;
            end
            #80 o_sck = 1'b1;
            rx_q = {rx_q[6:0], i_so};
            #80 o_sck = 1'b0;
        end
        o_si = ~o_si; // released line: no stale value
    endtask
endmodule

// ===== sep_pin_if.sv
// file: serial eeprom pin interface, link logic on the serial clock, session logic on sys clock
`timescale 1ns/1ps
module sep_pin_if
#(
    parameter logic [18:0] WC_CYCLES = sep_pkg::WRITE_CYCLE_CYCLES
)
(
    // system clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // serial pins
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_hold_n,
    input wire logic i_wp_n,
    output logic o_so_data,
    output logic o_so_oe,
    // read data stream from storage
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    // write record stream to storage
    output logic o_wr_valid,
    output sep_pkg::sep_wr_rec_t o_wr_rec,
    input wire logic i_wr_ready,
    // status view
    output logic [7:0] o_status
);
    // link domain state
    logic [2:0] bit_cnt_q; // bits taken in the current byte
    logic [6:0] shreg_q; // partial incoming byte
    logic [7:0] rx_byte_q; // last whole byte, stable until next toggle
    logic rx_tgl_q; // flips once per whole byte
    logic [6:0] tx_sh_q; // remaining outgoing bits
    logic tx_tgl_q; // flips once per outgoing byte load
    // sys domain state
    logic [sep_pkg::SY_N-1:0] sync_in; // raw lanes into the synchroniser
    logic [sep_pkg::SY_N-1:0] meta_q; // first stage, read only by second
    logic [sep_pkg::SY_N-1:0] sync_q; // second stage
    logic rx_seen_q; // last byte toggle consumed
    logic tx_seen_q; // last load toggle consumed
    logic [7:0] tx_word_q; // next byte the link will shift out
    logic [7:0] tx_hold_q; // one byte of read data from storage
    logic tx_hold_v_q; // read data byte held
    sep_pkg::sep_state_t state_q; // session state
    sep_pkg::sep_state_t state_d;
    logic [7:0] instr_q; // instruction of this session
    logic [15:0] addr_q; // address of next written byte
    logic got_data_q; // at least one data byte accepted
    logic [7:0] sr_pend_q; // status value awaiting session end
    logic [7:0] status_q; // status bits, busy bit kept apart
    logic [18:0] busy_cnt_q; // write cycle countdown
    logic [18:0] busy_len_q; // checking helper: busy run length
    // decoded conditions
    logic cs_s; // select, synchronised
    logic hold_s; // pause, synchronised
    logic wp_s; // protect pin, synchronised
    logic rx_evt; // whole byte waiting
    logic ld_evt; // link loaded an outgoing byte
    logic busy; // internal write cycle running
    logic fifo_in_ready; // buffer can take a record
    logic in_write_data; // data phase of a memory write
    logic rx_take; // byte consumed this cycle
    logic push; // record pushed to buffer
    logic end_ses; // session closes this cycle
    logic sr_try; // status write attempted at close
    logic sr_block; // pin protection active
    logic wc_start; // write cycle begins
    logic read_next; // next outgoing byte comes from storage
    logic [7:0] status_view; // status as the host reads it
    sep_pkg::sep_wr_rec_t rec; // record being pushed

    // shift in on rising clock; select high drops any partial byte
    always_ff @(posedge i_sck or posedge i_cs_n)
    begin
        if (i_cs_n)
        begin
            bit_cnt_q <= sep_pkg::BIT_FIRST;
            shreg_q <= '0;
        end
        else if (i_hold_n) // paused edges change nothing
        begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shreg_q <= {shreg_q[5:0], i_si};
        end
    end

    // whole byte hand-off; the toggle must survive select going high
    always_ff @(posedge i_sck or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rx_byte_q <= '0;
            rx_tgl_q <= 1'b0;
        end
        else if (i_hold_n && !i_cs_n && bit_cnt_q == sep_pkg::BIT_LAST)
        begin
            rx_byte_q <= {shreg_q, i_si};
            rx_tgl_q <= !rx_tgl_q;
        end
    end

    // shift out on falling clock, loading a fresh byte at each byte edge
    always_ff @(negedge i_sck or posedge i_cs_n)
    begin
        if (i_cs_n)
        begin
            o_so_data <= 1'b0;
            tx_sh_q <= '0;
        end
        else if (i_hold_n)
        begin
            if (bit_cnt_q == sep_pkg::BIT_FIRST)
            begin
                o_so_data <= tx_word_q[7];
                tx_sh_q <= tx_word_q[6:0];
            end
            else
            begin
                o_so_data <= tx_sh_q[6];
                tx_sh_q <= {tx_sh_q[5:0], 1'b0};
            end
        end
    end

    // load event toggle tells the sys side to prepare the next byte
    always_ff @(negedge i_sck or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            tx_tgl_q <= 1'b0;
        end
        else if (i_hold_n && !i_cs_n && bit_cnt_q == sep_pkg::BIT_FIRST)
        begin
            tx_tgl_q <= !tx_tgl_q;
        end
    end

    // two-flop synchronisers for pins and link toggles
    assign sync_in = {tx_tgl_q, rx_tgl_q, i_wp_n, i_hold_n, i_cs_n};
    for (genvar g = 0; g < sep_pkg::SY_N; g++)
    begin : g_sync
        always_ff @(posedge i_clk_sys)
        begin
            if (!i_nrst)
            begin
                meta_q[g] <= sep_pkg::SYNC_RESET[g];
                sync_q[g] <= sep_pkg::SYNC_RESET[g];
            end
            else
            begin
                meta_q[g] <= sync_in[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end

    // decoded conditions
    assign cs_s = sync_q[sep_pkg::SY_CS];
    assign hold_s = sync_q[sep_pkg::SY_HOLD];
    assign wp_s = sync_q[sep_pkg::SY_WP];
    assign rx_evt = sync_q[sep_pkg::SY_RX] ^ rx_seen_q;
    assign ld_evt = sync_q[sep_pkg::SY_TX] ^ tx_seen_q;
    assign busy = (busy_cnt_q != '0);
    assign in_write_data = (state_q == sep_pkg::ST_DATA) && (instr_q == sep_pkg::OP_WRITE);
    // a full buffer stalls byte intake rather than dropping a record
    assign rx_take = rx_evt && !(in_write_data && !fifo_in_ready);
    assign push = rx_take && in_write_data && status_q[sep_pkg::SR_LATCH_BIT];
    // pending bytes are finished before the close is honoured
    assign end_ses = (state_q != sep_pkg::ST_IDLE) && cs_s && !rx_evt;
    assign sr_block = !wp_s && status_q[sep_pkg::SR_PROTECT_PIN_ENABLE_BIT];
    assign sr_try = end_ses && (state_q == sep_pkg::ST_DATA) && (instr_q == sep_pkg::OP_WR_SR)
        && got_data_q && status_q[sep_pkg::SR_LATCH_BIT];
    assign wc_start = (sr_try && !sr_block) || (end_ses && in_write_data && got_data_q);
    assign read_next = (instr_q == sep_pkg::OP_READ)
        && (state_q == sep_pkg::ST_ADDR_LO || state_q == sep_pkg::ST_DATA);
    assign status_view = {status_q[7:1], busy};
    assign rec.addr = addr_q;
    assign rec.data = rx_byte_q;

    // session sequencing from opcode through data
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            sep_pkg::ST_IDLE:
                if (!cs_s)
                begin
                    state_d = sep_pkg::ST_OPCODE;
                end
            sep_pkg::ST_OPCODE:
                if (rx_take)
                begin
                    // a running write cycle lets only status reads through
                    if (busy && rx_byte_q != sep_pkg::OP_RD_SR)
                    begin
                        state_d = sep_pkg::ST_SKIP;
                    end
                    else if (rx_byte_q == sep_pkg::OP_WR_EN || rx_byte_q == sep_pkg::OP_WR_DIS)
                    begin
                        state_d = sep_pkg::ST_DONE;
                    end
                    else if (rx_byte_q == sep_pkg::OP_RD_SR || rx_byte_q == sep_pkg::OP_WR_SR)
                    begin
                        state_d = sep_pkg::ST_DATA;
                    end
                    else if (rx_byte_q == sep_pkg::OP_READ || rx_byte_q == sep_pkg::OP_WRITE)
                    begin
                        state_d = sep_pkg::ST_ADDR_HI;
                    end
                    else
                    begin
                        state_d = sep_pkg::ST_SKIP; // unknown code ignored
                    end
                end
            sep_pkg::ST_ADDR_HI:
                if (rx_take)
                begin
                    state_d = sep_pkg::ST_ADDR_LO;
                end
            sep_pkg::ST_ADDR_LO:
                if (rx_take)
                begin
                    state_d = sep_pkg::ST_DATA;
                end
            sep_pkg::ST_DONE:
                if (rx_take)
                begin
                    state_d = sep_pkg::ST_SKIP; // extra bytes void the command
                end
            sep_pkg::ST_DATA,
            sep_pkg::ST_SKIP:
                state_d = state_q;
            default:
                state_d = sep_pkg::ST_IDLE;
        endcase
        if (end_ses)
        begin
            state_d = sep_pkg::ST_IDLE; // unfinished framing is dropped here
        end
    end

    // session registers
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            state_q <= sep_pkg::ST_IDLE;
            rx_seen_q <= 1'b0;
            instr_q <= '0;
            addr_q <= '0;
            got_data_q <= 1'b0;
            sr_pend_q <= sep_pkg::SR_RESET;
        end
        else
        begin
            state_q <= state_d;
            if (rx_take)
            begin
                rx_seen_q <= sync_q[sep_pkg::SY_RX];
            end
            if (state_q == sep_pkg::ST_IDLE)
            begin
                got_data_q <= 1'b0;
            end
            if (rx_take && state_q == sep_pkg::ST_OPCODE)
            begin
                instr_q <= rx_byte_q;
            end
            if (rx_take && state_q == sep_pkg::ST_ADDR_HI)
            begin
                addr_q[15:8] <= rx_byte_q;
            end
            if (rx_take && state_q == sep_pkg::ST_ADDR_LO)
            begin
                addr_q[7:0] <= rx_byte_q;
            end
            if (push)
            begin
                addr_q <= addr_q + sep_pkg::ADDR_STEP;
                got_data_q <= 1'b1;
            end
            if (rx_take && state_q == sep_pkg::ST_DATA && instr_q == sep_pkg::OP_WR_SR
                && !got_data_q)
            begin
                sr_pend_q <= rx_byte_q; // only the first data byte counts
                got_data_q <= 1'b1;
            end
        end
    end

    // status bits: latch set or cleared at close, writes gated by the pin
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            status_q <= sep_pkg::SR_RESET;
        end
        else if (end_ses && state_q == sep_pkg::ST_DONE)
        begin
            status_q[sep_pkg::SR_LATCH_BIT] <= (instr_q == sep_pkg::OP_WR_EN);
        end
        else if (sr_try && !sr_block)
        begin
            status_q <= (status_q & ~sep_pkg::SR_WRITE_MASK)
                | (sr_pend_q & sep_pkg::SR_WRITE_MASK);
            status_q[sep_pkg::SR_LATCH_BIT] <= 1'b0;
        end
        else if (wc_start)
        begin
            status_q[sep_pkg::SR_LATCH_BIT] <= 1'b0;
        end
    end

    // write cycle timer runs on whatever select does afterwards
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            busy_cnt_q <= '0;
        end
        else if (wc_start)
        begin
            busy_cnt_q <= WC_CYCLES;
        end
        else if (busy)
        begin
            busy_cnt_q <= busy_cnt_q - 19'h00001;
        end
    end

    // next outgoing byte, changed right after the link took the last, and refreshed with status while idle
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            tx_seen_q <= 1'b0;
            tx_word_q <= sep_pkg::SR_RESET;
        end
        else if (ld_evt)
        begin
            tx_seen_q <= sync_q[sep_pkg::SY_TX];
            if (read_next)
            begin
                tx_word_q <= tx_hold_v_q ? tx_hold_q : sep_pkg::READ_FILL;
            end
            else
            begin
                tx_word_q <= status_view;
            end
        end
        else if (state_q == sep_pkg::ST_IDLE)
        begin
            tx_word_q <= status_view; // fresh status for the next session
        end
    end

    // one-byte holding slot for read data from storage
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            tx_hold_q <= '0;
            tx_hold_v_q <= 1'b0;
            o_tx_ready <= 1'b0;
        end
        else if (i_tx_valid && o_tx_ready)
        begin
            tx_hold_q <= i_tx_data;
            tx_hold_v_q <= 1'b1;
            o_tx_ready <= 1'b0;
        end
        else if (ld_evt && read_next && tx_hold_v_q)
        begin
            tx_hold_v_q <= 1'b0;
            o_tx_ready <= 1'b1;
        end
        else
        begin
            o_tx_ready <= !tx_hold_v_q;
        end
    end

    // output enable: only in a read phase, selected and not paused
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_so_oe <= 1'b0;
            o_status <= sep_pkg::SR_RESET;
        end
        else
        begin
            o_so_oe <= !cs_s && hold_s && (state_q == sep_pkg::ST_DATA)
                && (instr_q == sep_pkg::OP_READ || instr_q == sep_pkg::OP_RD_SR);
            o_status <= status_view;
        end
    end

    // write record buffer toward storage
    sep_fifo #(
        .WIDTH(sep_pkg::WR_REC_W),
        .DEPTH(sep_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .i_clk(i_clk_sys),
        .i_nrst(i_nrst),
        .i_in_valid(push),
        .i_in_data(rec),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(o_wr_valid),
        .o_out_data(o_wr_rec),
        .i_out_ready(i_wr_ready)
    );

    // checking helper: length of the current busy run
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst || !busy)
        begin
            busy_len_q <= '0;
        end
        else
        begin
            busy_len_q <= busy_len_q + 19'h00001;
        end
    end

    rx_sample_a: assert property (@(posedge i_sck) disable iff (i_cs_n)
        i_hold_n |=> shreg_q[0] == $past(i_si))
        else $error("data input not sampled on rising clock");
    so_shift_a: assert property (@(negedge i_sck) disable iff (i_cs_n)
        (i_hold_n && bit_cnt_q != sep_pkg::BIT_FIRST) |=> o_so_data == $past(tx_sh_q[6]))
        else $error("data output not shifted on falling clock");
    pause_freeze_a: assert property (@(posedge i_sck) disable iff (i_cs_n)
        !i_hold_n |=> bit_cnt_q == $past(bit_cnt_q))
        else $error("bit counter moved while paused");
    oe_deselect_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        cs_s |=> !o_so_oe)
        else $error("output driven while deselected");
    oe_pause_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (!hold_s ##1 hold_s && !cs_s && state_q == sep_pkg::ST_DATA
        && (instr_q == sep_pkg::OP_RD_SR || instr_q == sep_pkg::OP_READ))
        |-> !o_so_oe ##1 o_so_oe)
        else $error("output not floated in pause or not driven after");
    session_open_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (state_q == sep_pkg::ST_IDLE && !cs_s) |=> state_q == sep_pkg::ST_OPCODE)
        else $error("select fall did not open a session");
    partial_drop_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (end_ses && state_q != sep_pkg::ST_DATA && state_q != sep_pkg::ST_DONE)
        |=> state_q == sep_pkg::ST_IDLE && !$rose(busy) && $stable(status_q))
        else $error("partial transaction took effect");
    sr_refuse_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (sr_try && !wp_s && status_q[sep_pkg::SR_PROTECT_PIN_ENABLE_BIT])
        |=> status_q[7:2] == $past(status_q[7:2]) && !busy)
        else $error("status write taken while pin protected");
    sr_accept_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (sr_try && wp_s) |=> status_q[sep_pkg::SR_PROTECT_PIN_ENABLE_BIT]
        == $past(sr_pend_q[sep_pkg::SR_PROTECT_PIN_ENABLE_BIT]) && busy)
        else $error("status write blocked with pin high");
    wc_bound_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        busy_len_q <= WC_CYCLES)
        else $error("write cycle ran too long");

    write_cycle_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) $rose(busy));
    pause_read_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
        $fell(hold_s) && state_q == sep_pkg::ST_DATA);
    sr_refused_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) sr_try && sr_block);
    fifo_full_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) !fifo_in_ready);
endmodule

// ===== sep_pkg.sv
// package: constants, types and state codes for the serial eeprom pin interface
package sep_pkg;
    // serial framing: bit counter values at byte edges
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // instruction codes
    localparam logic [7:0] OP_WR_EN = 8'h06;
    localparam logic [7:0] OP_WR_DIS = 8'h04;
    localparam logic [7:0] OP_RD_SR = 8'h05;
    localparam logic [7:0] OP_WR_SR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    // status register fields
    localparam int SR_PROTECT_PIN_ENABLE_BIT = 7;
    localparam int SR_LATCH_BIT = 1;
    localparam int SR_BUSY_BIT = 0;
    localparam logic [7:0] SR_RESET = 8'h00;
    localparam logic [7:0] SR_WRITE_MASK = 8'h8C;
    // byte sent on a read when storage has nothing ready
    localparam logic [7:0] READ_FILL = 8'hFF;
    // write record address step
    localparam logic [15:0] ADDR_STEP = 16'h0001;
    // timing
    localparam int CLK_SYS_MHZ = 100;
    localparam int WRITE_CYCLE_TIME_MAX_MS = 4;
    localparam logic [18:0] WRITE_CYCLE_CYCLES =
        19'(WRITE_CYCLE_TIME_MAX_MS * CLK_SYS_MHZ * 1000);
    // write record buffer depth
    localparam int FIFO_DEPTH = 16;
    // synchroniser lanes
    localparam int SY_CS = 0;
    localparam int SY_HOLD = 1;
    localparam int SY_WP = 2;
    localparam int SY_RX = 3;
    localparam int SY_TX = 4;
    localparam int SY_N = 5;
    localparam logic [4:0] SYNC_RESET = 5'h07;
    // session states
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR_HI = 3'b010,
        ST_ADDR_LO = 3'b011,
        ST_DATA = 3'b100,
        ST_DONE = 3'b101,
        ST_SKIP = 3'b110
    } sep_state_t;
    // one byte to be written to storage
    typedef struct packed
    {
        logic [15:0] addr;
        logic [7:0] data;
    } sep_wr_rec_t;
    localparam int WR_REC_W = $bits(sep_wr_rec_t);
endpackage

// ===== testbench.sv
// bench for the serial pin interface
`timescale 1ns/1ps
module testbench;
    localparam logic [18:0] WC = 19'h00032; // short write cycle
    logic clk, nrst, wp_n, tx_valid, wr_ready, so_last;
    logic sck, cs_n, si, hold_n, so_data, so_oe, wr_valid, tx_ready;
    logic [7:0] tx_data, status;
    sep_pkg::sep_wr_rec_t wr_rec;
    sep_pkg::sep_wr_rec_t recs[$];
    int errors, n_checks;
    int cyc = 0; // sys cycles, only the run limit counts them
    always @* if (so_oe) so_last = so_data;
    wire so = so_oe ? so_data : ~so_last; // floating line
    sep_pin_if #(.WC_CYCLES(WC)) dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_sck(sck),
        .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so_data(so_data),
        .o_so_oe(so_oe), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
        .o_wr_valid(wr_valid), .o_wr_rec(wr_rec), .i_wr_ready(wr_ready), .o_status(status));
    sep_host host_u (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n), .i_so(so));
    always @(posedge clk)
    begin
        if (wr_valid && wr_ready)
            recs.push_back(wr_rec);
        cyc <= cyc + 1;
        if (cyc == 70000)
        begin
            errors++;
            final_report();
        end
    end
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic frame(input logic [7:0] a, b, c, input int n);
        host_u.open_s();
        host_u.xbyte(a, 1'b0);
        if (n > 1) host_u.xbyte(b, 1'b0);
        if (n > 2) host_u.xbyte(c, 1'b0);
        host_u.close_s();
        repeat (int'(WC) + 8) @(negedge clk);
    endtask
    task automatic rdsr(input logic [7:0] exp);
        frame(8'h05, 8'h00, 8'h00, 2);
        check(24'(host_u.rx_q), 24'(exp));
    endtask
    task automatic t_write();
        frame(8'h06, 8'h00, 8'h00, 1);
        wr_ready = 1'b0;
        // one session: opcode, two address bytes, two data bytes
        host_u.open_s();
        host_u.xbyte(8'h02, 1'b0);
        host_u.xbyte(8'h12, 1'b0);
        host_u.xbyte(8'h34, 1'b0);
        host_u.xbyte(8'hA5, 1'b0);
        host_u.xbyte(8'h5A, 1'b0);
        host_u.close_s();
        @(negedge clk);
        check(24'(status[0]), 24'h1);
        repeat (int'(WC) + 8) @(negedge clk);
        check(24'(status), 24'h000000);
        wr_ready = 1'b1;
        repeat (4) @(negedge clk);
        check(recs.pop_front(), 24'h1234A5);
        check(recs.pop_front(), 24'h12355A);
    endtask
    task automatic t_protect();
        frame(8'h06, 8'h00, 8'h00, 1);
        frame(8'h01, 8'h8C, 8'h00, 2);
        rdsr(8'h8C);
        wp_n = 1'b0;
        frame(8'h06, 8'h00, 8'h00, 1);
        frame(8'h01, 8'h00, 8'h00, 2);
        check(24'(status[7]), 24'h1);
        wp_n = 1'b1;
        frame(8'h01, 8'h00, 8'h00, 2);
        rdsr(8'h00);
    endtask
    task automatic t_pause();
        host_u.open_s();
        host_u.xbyte(8'h03, 1'b0);
        host_u.xbyte(8'h00, 1'b0);
        host_u.xbyte(8'h10, 1'b0);
        fork
            host_u.xbyte(8'h00, 1'b1);
            begin
                wait (!hold_n);
                #60 check(24'(so_oe), 24'h0);
                wait (hold_n);
                #60 check(24'(so_oe), 24'h1);
            end
        join
        host_u.close_s();
        check(24'(host_u.rx_q), 24'hC3);
        check(24'(so_oe), 24'h0);
        check(24'(tx_ready), 24'h0);
    endtask
    task automatic t_abort();
        frame(8'h06, 8'h00, 8'h00, 1);
        frame(8'h02, 8'h12, 8'h00, 2);
        check(24'(recs.size()), 24'h0);
        rdsr(8'h02);
        frame(8'h04, 8'h00, 8'h00, 1);
        rdsr(8'h00);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        {nrst, errors, n_checks} = '0;
        {wp_n, tx_valid, wr_ready, tx_data} = {3'h7, 8'hC3};
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        #350000; // power-up wait
        rdsr(8'h00);
        t_write();
        t_protect();
        t_pause();
        t_abort();
        final_report();
    end
endmodule
